// >>> fmr_ctrl.sv
// Flowmeter input action, relay, batch and analog control with AXI4-Lite registers
// Overview of operation
// - Each input pin carries one selectable action
// - Total-reset action clears the flow total
// - Alarm-reset action clears alarms on alarm pins
// - Meter-reset action resets functional state, keeps bus and register setup
// - Start/pause toggles batch; use one edge only
// - Batch-reset arms new batch, zeroes batch total
// - Trigger edge: rising, falling or both
// - Relay modes: unused, flow switch, batch
// - Flow switch compares filtered flow rate
// - Positive hysteresis: on above thr+hyst, off below thr
// - Negative hysteresis: on below thr-hyst, off above thr
// - Relay starts off; hysteresis is percent of threshold
// - Batch relay on at start, off at target
// - Completed batch waits for reset before restart
// - Further start/pause triggers pause and resume delivery
// - Batch volume shown, cleared by batch reset
// - Relay off at predicted target, no valve delay
// - Optional decrement of batch total on reverse flow
// - Analog mode: unused, 4-20mA, 0-5V, 0-10V
// - Flow status refreshed about every 100 ms
// - Latched alarm cleared by input or long hold
// - Sinking output: inactive released high, active pulls low
`timescale 1ns/1ps
module fmr_ctrl #(
  parameter int STAT_CYC = fmr_pkg::FMR_STAT_CYC,
  parameter int HOLD_CYC = fmr_pkg::FMR_HOLD_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire fmr_pkg::fmr_axi_req_s axi_req,
  output fmr_pkg::fmr_axi_rsp_s axi_rsp,
  // Input pins and front-panel buttons
  input wire logic [1:0] pin_i,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe,
  input wire logic btn_left,
  input wire logic btn_right,
  // Flow measurements
  input wire logic signed [15:0] flow_filt,
  input wire logic signed [15:0] flow_raw,
  input wire logic vol_vld,
  input wire logic signed [15:0] vol_delta,
  input wire logic [1:0] alarm_cond,
  // Actions and outputs
  output logic total_clr,
  output logic alarm_clr,
  output logic meter_rst,
  output logic relay_on,
  output logic [1:0] analog_mode,
  output logic [15:0] analog_code,
  output logic [31:0] batch_total,
  output logic [15:0] flow_status
);
  import fmr_pkg::*;

  fmr_state_s st;
  fmr_state_s nx;
  logic [5:0] fire;
  logic lpress;
  logic rpress;
  logic bstart;
  logic breset;
  logic meter_hit;
  logic alarm_hit;
  logic signed [24:0] on_lvl;

  // Byte-lane merge of a write
  function automatic logic [31:0] fmr_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : fmr_merge

  // Writable register decode
  function automatic logic fmr_wr_ok(input logic [FMR_AW-1:0] a);
    return a[FMR_AW-1:2] inside {FMR_OFF_CTRL[FMR_AW-1:2], FMR_OFF_PINCFG[FMR_AW-1:2],
      FMR_OFF_THRESH[FMR_AW-1:2], FMR_OFF_TARGET[FMR_AW-1:2], FMR_OFF_ANALIM[FMR_AW-1:2]};
  endfunction : fmr_wr_ok

  // Edge qualification
  function automatic logic fmr_fire(input logic [1:0] sel, input logic rise, input logic fall);
    case (fmr_edge_e'(sel))
      EDGE_RISE: return rise;
      EDGE_FALL: return fall;
      EDGE_BOTH: return rise | fall;
      default: return 1'b0;
    endcase
  endfunction : fmr_fire

  // Next-state logic
  always_comb begin
    logic signed [23:0] hyst_amt;
    logic signed [31:0] tot;
    logic signed [16:0] span;
    logic signed [33:0] scaled;
    logic [2:0] act;
    logic [FMR_AW-1:0] ra;
    hyst_amt = '0;
    tot = '0;
    span = '0;
    scaled = '0;
    act = '0;
    ra = '0;
    nx = st;
    nx.total_clr = 1'b0;
    nx.alarm_clr = 1'b0;
    nx.meter_rst = 1'b0;
    // Two-stage synchroniser, third stage for edges
    nx.s1 = pin_i;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    nx.lprev = btn_left;
    nx.rprev = btn_right;
    fire = '0;
    for (int i = 0; i < 2; i++) begin
      act = st.pincfg[FMR_PIN_STRIDE*i +: 3];
      if (st.ctrl[FMR_CTRL_DIR+i] && fmr_fire(st.pincfg[FMR_PIN_STRIDE*i+FMR_PIN_EDGE +: 2],
          st.s2[i] & ~st.s3[i], ~st.s2[i] & st.s3[i])) begin
        if (act <= 3'(ACT_BRESET)) begin
          fire[act] = 1'b1;
        end
      end
    end
    lpress = btn_left & ~st.lprev;
    rpress = btn_right & ~st.rprev;
    meter_hit = fire[ACT_METER];
    // Total reset from input or right button
    nx.total_clr = fire[ACT_TOTAL] | rpress;
    // Left-button hold timer for latched alarms
    nx.hold_cnt = btn_left ? ((st.hold_cnt == FMR_CW'(HOLD_CYC)) ? st.hold_cnt :
                  st.hold_cnt + FMR_CW'(1)) : '0;
    alarm_hit = fire[ACT_ALARM] | (btn_left && st.hold_cnt == FMR_CW'(HOLD_CYC - 1));
    nx.alarm_clr = alarm_hit;
    nx.alarm_lat = (st.alarm_lat & ~{2{alarm_hit}}) | alarm_cond;
    // Sinking drive: pull low while alarm active
    nx.pin_o = 2'b00;
    nx.pin_oe = ~st.ctrl[FMR_CTRL_DIR +: 2] & nx.alarm_lat;
    // Batch sequencer
    bstart = fire[ACT_BSTART] | (lpress && st.ctrl[FMR_CTRL_RELAY +: 2] == 2'(RLY_BATCH));
    breset = fire[ACT_BRESET] | (rpress && st.ctrl[FMR_CTRL_RELAY +: 2] == 2'(RLY_BATCH));
    case (st.batch)
      B_ARMED: if (bstart) begin
        nx.batch = B_RUN;
      end
      B_RUN: if (bstart) begin
        nx.batch = B_PAUSE;
      end
      B_PAUSE: if (bstart) begin
        nx.batch = B_RUN;
      end
      B_DONE: nx.batch = B_DONE;
      default: nx.batch = B_ARMED;
    endcase
    tot = st.btotal;
    if (vol_vld && (st.batch == B_RUN || st.batch == B_PAUSE)) begin
      if (vol_delta >= 0 || st.ctrl[FMR_CTRL_DECNEG]) begin
        tot = st.btotal + 32'(vol_delta);
      end
    end
    nx.btotal = tot;
    // Stop when the next increment at this flow would reach the target
    if (st.batch == B_RUN && (tot >= $signed(st.target) ||
        (vol_vld && vol_delta > 0 && tot + 32'(vol_delta) >= $signed(st.target)))) begin
      nx.batch = B_DONE;
    end
    if (breset) begin
      nx.batch = B_ARMED;
      nx.btotal = '0;
    end
    if (st.ctrl[FMR_CTRL_RELAY +: 2] != 2'(RLY_BATCH)) begin
      nx.batch = B_ARMED;
    end
    // Relay per mode, hysteresis as percent of threshold
    hyst_amt = 24'(($signed(st.thresh[15:0]) * $signed(st.thresh[FMR_THR_HYST +: 8]))
               / FMR_PCT);
    on_lvl = 25'($signed(st.thresh[15:0])) + 25'(hyst_amt);
    case (fmr_relay_e'(st.ctrl[FMR_CTRL_RELAY +: 2]))
      RLY_FLOW: begin
        if (!st.thresh[FMR_THR_HYST+7]) begin
          if (25'(flow_filt) > on_lvl) begin
            nx.relay = 1'b1;
          end else if (flow_filt < $signed(st.thresh[15:0])) begin
            nx.relay = 1'b0;
          end
        end else begin
          if (25'(flow_filt) < on_lvl) begin
            nx.relay = 1'b1;
          end else if (flow_filt > $signed(st.thresh[15:0])) begin
            nx.relay = 1'b0;
          end
        end
      end
      RLY_BATCH: nx.relay = (nx.batch == B_RUN);
      default: nx.relay = 1'b0;
    endcase
    // Flow status refresh
    if (st.stat_cnt >= FMR_CW'(STAT_CYC - 1)) begin
      nx.stat_cnt = '0;
      nx.flow_stat = flow_raw;
    end else begin
      nx.stat_cnt = st.stat_cnt + FMR_CW'(1);
    end
    // Analog code scaling with clamping
    span = 17'($signed(st.analim[FMR_ANA_HI +: 16])) - 17'($signed(st.analim[15:0]));
    if (st.ctrl[FMR_CTRL_ANA +: 2] == 2'(ANA_OFF)) begin
      nx.ana_code = '0;
    end else if (flow_filt <= $signed(st.analim[15:0])) begin
      nx.ana_code = '0;
    end else if (flow_filt >= $signed(st.analim[FMR_ANA_HI +: 16]) || span <= 0) begin
      nx.ana_code = FMR_ANA_FULL;
    end else begin
      scaled = (34'(flow_filt) - 34'($signed(st.analim[15:0]))) *
               34'($signed({1'b0, FMR_ANA_FULL})) / 34'(span);
      nx.ana_code = scaled[15:0];
    end
    // AXI4-Lite write path
    if (st.rsp.awready && axi_req.awvalid) begin
      nx.aw_got = 1'b1;
      nx.awaddr = axi_req.awaddr;
    end
    if (st.rsp.wready && axi_req.wvalid) begin
      nx.w_got = 1'b1;
      nx.wdata = axi_req.wdata;
      nx.wstrb = axi_req.wstrb;
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      nx.rsp.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.rsp.bvalid) begin
      nx.aw_got = 1'b0;
      nx.w_got = 1'b0;
      nx.rsp.bvalid = 1'b1;
      nx.rsp.bresp = fmr_wr_ok(st.awaddr) ? FMR_RESP_OKAY : FMR_RESP_SLVERR;
      case (st.awaddr[FMR_AW-1:2])
        FMR_OFF_CTRL[FMR_AW-1:2]: nx.ctrl = fmr_merge(st.ctrl, st.wdata, st.wstrb);
        FMR_OFF_PINCFG[FMR_AW-1:2]: nx.pincfg = fmr_merge(st.pincfg, st.wdata, st.wstrb);
        FMR_OFF_THRESH[FMR_AW-1:2]: nx.thresh = fmr_merge(st.thresh, st.wdata, st.wstrb);
        FMR_OFF_TARGET[FMR_AW-1:2]: nx.target = fmr_merge(st.target, st.wdata, st.wstrb);
        FMR_OFF_ANALIM[FMR_AW-1:2]: nx.analim = fmr_merge(st.analim, st.wdata, st.wstrb);
        default: nx.ctrl = st.ctrl;
      endcase
    end
    // AXI4-Lite read path
    if (st.rsp.rvalid && axi_req.rready) begin
      nx.rsp.rvalid = 1'b0;
    end
    if (st.rsp.arready && axi_req.arvalid) begin
      ra = axi_req.araddr;
      nx.rsp.rvalid = 1'b1;
      nx.rsp.rresp = FMR_RESP_OKAY;
      case (ra[FMR_AW-1:2])
        FMR_OFF_CTRL[FMR_AW-1:2]: nx.rsp.rdata = st.ctrl;
        FMR_OFF_PINCFG[FMR_AW-1:2]: nx.rsp.rdata = st.pincfg;
        FMR_OFF_THRESH[FMR_AW-1:2]: nx.rsp.rdata = st.thresh;
        FMR_OFF_TARGET[FMR_AW-1:2]: nx.rsp.rdata = st.target;
        FMR_OFF_ANALIM[FMR_AW-1:2]: nx.rsp.rdata = st.analim;
        FMR_OFF_STATUS[FMR_AW-1:2]: nx.rsp.rdata = {25'h0, st.s2, st.alarm_lat, st.batch,
                                                    st.relay};
        FMR_OFF_BTOTAL[FMR_AW-1:2]: nx.rsp.rdata = st.btotal;
        FMR_OFF_FLOW[FMR_AW-1:2]: nx.rsp.rdata = {{16{st.flow_stat[15]}}, st.flow_stat};
        default: begin
          nx.rsp.rdata = 32'h0000_0000;
          nx.rsp.rresp = FMR_RESP_SLVERR;
        end
      endcase
    end
    // Meter reset: functional state back to reset, bus and setup kept
    if (meter_hit) begin
      nx.batch = FMR_ST_RST.batch;
      nx.btotal = FMR_ST_RST.btotal;
      nx.relay = FMR_ST_RST.relay;
      nx.alarm_lat = FMR_ST_RST.alarm_lat;
      nx.pin_oe = FMR_ST_RST.pin_oe;
      nx.flow_stat = FMR_ST_RST.flow_stat;
      nx.stat_cnt = FMR_ST_RST.stat_cnt;
      nx.ana_code = FMR_ST_RST.ana_code;
      nx.total_clr = 1'b1;
      nx.meter_rst = 1'b1;
    end
    nx.rsp.awready = !nx.aw_got && !nx.rsp.bvalid;
    nx.rsp.wready = !nx.w_got && !nx.rsp.bvalid;
    nx.rsp.arready = !nx.rsp.rvalid;
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= FMR_ST_RST;
    end else begin
      st <= nx;
    end
  end

  // Outputs from the state register
  assign axi_rsp = st.rsp;
  assign pin_o = st.pin_o;
  assign pin_oe = st.pin_oe;
  assign total_clr = st.total_clr;
  assign alarm_clr = st.alarm_clr;
  assign meter_rst = st.meter_rst;
  assign relay_on = st.relay;
  assign analog_mode = st.ctrl[FMR_CTRL_ANA +: 2];
  assign analog_code = st.ana_code;
  assign batch_total = st.btotal;
  assign flow_status = st.flow_stat;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rise0;
    st.s2[0] && !st.s3[0] && st.ctrl[FMR_CTRL_DIR] && st.pincfg[2:0] == 3'(ACT_TOTAL) &&
    st.pincfg[FMR_PIN_EDGE +: 2] == 2'(EDGE_RISE);
  endsequence
  sequence s_meter_pulse;
    meter_rst ##1 !meter_rst;
  endsequence

  property p_total_edge;
    s_rise0 |=> total_clr;
  endproperty
  a_total_edge: assert property (p_total_edge) else $error("edge did not clear total");
  property p_relay_off;
    st.ctrl[FMR_CTRL_RELAY +: 2] == 2'(RLY_OFF) |=> !relay_on;
  endproperty
  a_relay_off: assert property (p_relay_off) else $error("relay on while unused");
  property p_batch_relay;
    st.ctrl[FMR_CTRL_RELAY +: 2] == 2'(RLY_BATCH) |=> relay_on == (st.batch == B_RUN);
  endproperty
  a_batch_relay: assert property (p_batch_relay) else $error("batch relay mismatch");
  property p_done_hold;
    st.batch == B_DONE && !breset && !meter_hit &&
    st.ctrl[FMR_CTRL_RELAY +: 2] == 2'(RLY_BATCH) |=> st.batch == B_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done batch left early");
  property p_breset;
    breset |=> batch_total == 32'h0000_0000 && st.batch == B_ARMED;
  endproperty
  a_breset: assert property (p_breset) else $error("batch reset failed");
  property p_resume;
    st.batch == B_PAUSE && bstart && !breset && !meter_hit &&
    st.ctrl[FMR_CTRL_RELAY +: 2] == 2'(RLY_BATCH) |=> st.batch == B_RUN && relay_on;
  endproperty
  a_resume: assert property (p_resume) else $error("pause did not resume");
  property p_alarm_set;
    alarm_cond[0] && !meter_hit |=> st.alarm_lat[0] && (pin_oe[0] == !st.ctrl[FMR_CTRL_DIR]);
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm not latched");
  property p_flow_stat;
    st.stat_cnt == FMR_CW'(STAT_CYC - 1) && !meter_hit |=> flow_status == $past(flow_raw);
  endproperty
  a_flow_stat: assert property (p_flow_stat) else $error("flow status not refreshed");
  property p_pos_hyst;
    st.ctrl[FMR_CTRL_RELAY +: 2] == 2'(RLY_FLOW) && !st.thresh[FMR_THR_HYST+7] &&
    25'(flow_filt) > on_lvl && !meter_hit |=> relay_on;
  endproperty
  a_pos_hyst: assert property (p_pos_hyst) else $error("relay missed upper level");
  property p_meter;
    meter_hit |=> s_meter_pulse;
  endproperty
  a_meter: assert property (p_meter) else $error("meter reset pulse wrong");
endmodule : fmr_ctrl

// >>> fmr_far_model.sv
// Far-side model: switches on the input pins and the relay-driven valve
`timescale 1ns/1ps
module fmr_far_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Switches and pin wires
  input wire logic [1:0] sw_lvl,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_lvl,
  // Valve and flow
  input wire logic relay_on,
  input wire logic signed [15:0] rate,
  output logic vol_vld,
  output logic signed [15:0] vol_delta
);
  logic [1:0] tick;
  // Wire follows the switch level unless the sinking output pulls it low
  assign pin_lvl = sw_lvl & ~pin_oe;
  // Open valve passes one increment every fourth cycle; closed valve passes none
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick <= 2'h0;
      vol_vld <= 1'b0;
      vol_delta <= 16'h0000;
    end else if (relay_on) begin
      tick <= tick + 2'h1;
      vol_vld <= (tick == 2'h3);
      vol_delta <= (tick == 2'h3) ? rate : ~vol_delta;
    end else begin
      vol_vld <= 1'b0;
      vol_delta <= ~vol_delta; // Stale data is never left standing
    end
  end
endmodule : fmr_far_model

// >>> fmr_pkg.sv
// Constants, types and register map of the flowmeter input/relay/batch controller
package fmr_pkg;
  // Clock and timing
  localparam int FMR_CLK_HZ = 50_000_000;
  localparam int FMR_STAT_MS = 100;
  localparam int FMR_STAT_CYC = FMR_CLK_HZ / 1000 * FMR_STAT_MS;
  localparam int FMR_HOLD_S = 4;
  localparam int FMR_HOLD_CYC = FMR_CLK_HZ * FMR_HOLD_S;
  localparam int FMR_CW = 28;
  localparam int FMR_AW = 8;
  localparam int FMR_PCT = 100;
  // Register byte offsets
  localparam logic [FMR_AW-1:0] FMR_OFF_CTRL = 8'h00;
  localparam logic [FMR_AW-1:0] FMR_OFF_PINCFG = 8'h04;
  localparam logic [FMR_AW-1:0] FMR_OFF_THRESH = 8'h08;
  localparam logic [FMR_AW-1:0] FMR_OFF_TARGET = 8'h0C;
  localparam logic [FMR_AW-1:0] FMR_OFF_ANALIM = 8'h10;
  localparam logic [FMR_AW-1:0] FMR_OFF_STATUS = 8'h14;
  localparam logic [FMR_AW-1:0] FMR_OFF_BTOTAL = 8'h18;
  localparam logic [FMR_AW-1:0] FMR_OFF_FLOW = 8'h1C;
  // Field positions
  localparam int FMR_CTRL_RELAY = 0;
  localparam int FMR_CTRL_ANA = 2;
  localparam int FMR_CTRL_DECNEG = 4;
  localparam int FMR_CTRL_DIR = 6;
  localparam int FMR_PIN_STRIDE = 8;
  localparam int FMR_PIN_EDGE = 3;
  localparam int FMR_THR_HYST = 16;
  localparam int FMR_ANA_HI = 16;
  // Responses and scale
  localparam logic [1:0] FMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] FMR_RESP_SLVERR = 2'h2;
  localparam logic [15:0] FMR_ANA_FULL = 16'hFFFF;
  // Enumerations
  typedef enum logic [2:0] {ACT_NONE, ACT_TOTAL, ACT_ALARM, ACT_METER, ACT_BSTART,
                            ACT_BRESET} fmr_act_e;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} fmr_edge_e;
  typedef enum logic [1:0] {RLY_OFF, RLY_FLOW, RLY_BATCH} fmr_relay_e;
  typedef enum logic [1:0] {ANA_OFF, ANA_4_20MA, ANA_0_5V, ANA_0_10V} fmr_ana_e;
  typedef enum logic [1:0] {B_ARMED, B_RUN, B_PAUSE, B_DONE} fmr_batch_e;
  // AXI4-Lite carriers
  typedef struct packed {
    logic awvalid; logic [FMR_AW-1:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [FMR_AW-1:0] araddr; logic rready;
  } fmr_axi_req_s;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } fmr_axi_rsp_s;
  // Whole state of the block
  typedef struct packed {
    fmr_axi_rsp_s rsp; logic aw_got; logic w_got; logic [FMR_AW-1:0] awaddr;
    logic [31:0] wdata; logic [3:0] wstrb;
    logic [31:0] ctrl; logic [31:0] pincfg; logic [31:0] thresh; logic [31:0] target;
    logic [31:0] analim;
    logic [1:0] s1; logic [1:0] s2; logic [1:0] s3; logic lprev; logic rprev;
    fmr_batch_e batch; logic [31:0] btotal; logic relay;
    logic [15:0] flow_stat; logic [FMR_CW-1:0] stat_cnt; logic [FMR_CW-1:0] hold_cnt;
    logic [1:0] alarm_lat; logic [1:0] pin_oe; logic [1:0] pin_o;
    logic total_clr; logic alarm_clr; logic meter_rst; logic [15:0] ana_code;
  } fmr_state_s;
  localparam fmr_state_s FMR_ST_RST = '0;
endpackage : fmr_pkg

// >>> tb_fmr_ctrl.sv
// Self-checking testbench of the flowmeter input, relay and batch controller
`timescale 1ns/1ps
module tb_fmr_ctrl;
  import fmr_pkg::*;
  localparam int STAT = 16;
  localparam int HOLD = 20;
  logic sys_clk, rst_n, btn_l, btn_r, vol_vld, total_clr, alarm_clr, meter_rst, relay_on;
  fmr_axi_req_s req;
  fmr_axi_rsp_s rsp;
  logic [1:0] sw_lvl, pin_lvl, pin_o, pin_oe, alarm_cond, analog_mode;
  logic signed [15:0] flow_filt, flow_raw, vol_delta, rate;
  logic [15:0] analog_code, flow_status;
  logic [31:0] batch_total;
  int miscompares, tests_run, n_tot, n_alm, n_met;
  // Device and far side
  fmr_ctrl #(.STAT_CYC(STAT), .HOLD_CYC(HOLD)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .axi_req(req), .axi_rsp(rsp), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe(pin_oe),
    .btn_left(btn_l), .btn_right(btn_r), .flow_filt(flow_filt), .flow_raw(flow_raw),
    .vol_vld(vol_vld), .vol_delta(vol_delta), .alarm_cond(alarm_cond),
    .total_clr(total_clr), .alarm_clr(alarm_clr), .meter_rst(meter_rst),
    .relay_on(relay_on), .analog_mode(analog_mode), .analog_code(analog_code),
    .batch_total(batch_total), .flow_status(flow_status));
  fmr_far_model i_far (.sys_clk(sys_clk), .rst_n(rst_n), .sw_lvl(sw_lvl), .pin_oe(pin_oe),
    .pin_lvl(pin_lvl), .relay_on(relay_on), .rate(rate), .vol_vld(vol_vld),
    .vol_delta(vol_delta));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Pulse cycles counted where outputs are settled
  always @(negedge sys_clk) begin
    n_tot += (total_clr === 1'b1);
    n_alm += (alarm_clr === 1'b1);
    n_met += (meter_rst === 1'b1);
  end
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tmo(input string nm);
    chk(nm, 32'h1, 32'h0);
    complete_run();
  endtask : tmo
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // AXI4-Lite write, released channel by channel as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b, ta, tw;
    logic [1:0] r;
    int n;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    n = 0;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!b) begin
      @(negedge sys_clk);
      ta = aw && (rsp.awready === 1'b1);
      tw = w && (rsp.wready === 1'b1);
      if (rsp.bvalid === 1'b1) begin
        b = 1'b1;
        r = rsp.bresp;
      end
      @(posedge sys_clk);
      if (ta) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (tw) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
      if (b) req.bready <= 1'b0;
      n++;
      if (n > 50) tmo("axi_write_wait");
    end
    chk("bresp", 32'(er), 32'(r));
  endtask : wr
  // AXI4-Lite read
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ar, g, t;
    logic [1:0] r;
    int n;
    ar = 1'b1;
    g = 1'b0;
    n = 0;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!g) begin
      @(negedge sys_clk);
      t = ar && (rsp.arready === 1'b1);
      if (rsp.rvalid === 1'b1) begin
        g = 1'b1;
        d = rsp.rdata;
        r = rsp.rresp;
      end
      @(posedge sys_clk);
      if (t) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
      if (g) req.rready <= 1'b0;
      n++;
      if (n > 50) tmo("axi_read_wait");
    end
    chk("rresp", 32'(er), 32'(r));
  endtask : rd
  task automatic pin(input int i, input logic v);
    @(posedge sys_clk);
    sw_lvl[i] <= v;
    cyc(6);
  endtask : pin
  task automatic press(input logic left);
    @(posedge sys_clk);
    if (left) btn_l <= 1'b1;
    else btn_r <= 1'b1;
    @(posedge sys_clk);
    btn_l <= 1'b0;
    btn_r <= 1'b0;
    cyc(3);
  endtask : press
  // Reset values, read-only refusal and unmapped address
  task automatic t_regs();
    logic [31:0] d;
    rd(FMR_OFF_CTRL, FMR_RESP_OKAY, d);
    chk("ctrl_reset", 32'h0, d);
    rd(FMR_OFF_STATUS, FMR_RESP_OKAY, d);
    chk("status_reset", 32'h0, d);
    wr(FMR_OFF_TARGET, 32'h0000_0123, FMR_RESP_OKAY);
    rd(FMR_OFF_TARGET, FMR_RESP_OKAY, d);
    chk("target", 32'h0000_0123, d);
    wr(FMR_OFF_STATUS, 32'hFFFF_FFFF, FMR_RESP_SLVERR);
    rd(8'h20, FMR_RESP_SLVERR, d);
    chk("unmapped", 32'h0, d);
  endtask : t_regs
  // Every clear action under every edge choice, then a pin not set as input
  task automatic t_pins();
    int a, e, b0, b1, b2, x, g;
    wr(FMR_OFF_CTRL, 32'h0000_0040, FMR_RESP_OKAY);
    for (a = 1; a <= 3; a++) begin
      for (e = 0; e <= 3; e++) begin
        wr(FMR_OFF_PINCFG, 32'(a | (e << 3)), FMR_RESP_OKAY);
        b0 = n_tot;
        b1 = n_alm;
        b2 = n_met;
        pin(0, 1'b1);
        pin(0, 1'b0);
        x = (e == 3) ? 0 : ((e == 2) ? 2 : 1);
        g = (a == 1) ? n_tot - b0 : ((a == 2) ? n_alm - b1 : n_met - b2);
        chk("action_pulses", 32'(x), 32'(g));
      end
    end
    wr(FMR_OFF_PINCFG, 32'h0000_0001, FMR_RESP_OKAY);
    wr(FMR_OFF_CTRL, 32'h0000_0000, FMR_RESP_OKAY);
    b0 = n_tot;
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk("not_input", 32'(b0), 32'(n_tot));
  endtask : t_pins
  // Alarm on the sinking pin, cleared by input action and by a long hold
  task automatic t_alarm();
    int b1;
    wr(FMR_OFF_CTRL, 32'h0000_0040, FMR_RESP_OKAY);
    wr(FMR_OFF_PINCFG, 32'h0000_0002, FMR_RESP_OKAY);
    sw_lvl[1] <= 1'b1;
    @(posedge sys_clk);
    alarm_cond <= 2'b11;
    @(posedge sys_clk);
    alarm_cond <= 2'b00;
    cyc(3);
    chk("oe_set", 32'h2, 32'(pin_oe));
    chk("pin1_low", 32'h0, 32'({pin_o[1], pin_lvl[1]}));
    pin(0, 1'b1);
    chk("oe_clr", 32'h0, 32'(pin_oe));
    chk("pin1_high", 32'h1, 32'(pin_lvl[1]));
    @(posedge sys_clk);
    alarm_cond <= 2'b10;
    @(posedge sys_clk);
    alarm_cond <= 2'b00;
    btn_l <= 1'b1;
    cyc(HOLD / 2);
    btn_l <= 1'b0;
    cyc(3);
    chk("short_hold", 32'h2, 32'(pin_oe));
    b1 = n_alm;
    btn_l <= 1'b1;
    cyc(HOLD + 5);
    btn_l <= 1'b0;
    cyc(3);
    chk("hold_pulse", 32'h1, 32'(n_alm - b1));
    chk("hold_clr", 32'h0, 32'(pin_oe));
    pin(0, 1'b0);
  endtask : t_alarm
  // Flow switch with positive and negative percentage hysteresis
  task automatic t_flow();
    int fv [8] = '{239, 241, 220, 199, 161, 159, 190, 201};
    int ev [8] = '{0, 1, 1, 0, 0, 1, 1, 0};
    int i;
    flow_filt <= 16'sd300;
    cyc(4);
    chk("relay_unused", 32'h0, 32'(relay_on));
    flow_filt <= 16'sd0;
    wr(FMR_OFF_THRESH, 32'h0014_00C8, FMR_RESP_OKAY);
    wr(FMR_OFF_CTRL, 32'h0000_0001, FMR_RESP_OKAY);
    cyc(4);
    chk("relay_start", 32'h0, 32'(relay_on));
    for (i = 0; i < 8; i++) begin
      if (i == 4) wr(FMR_OFF_THRESH, 32'h00EC_00C8, FMR_RESP_OKAY);
      @(posedge sys_clk);
      flow_filt <= 16'(fv[i]);
      flow_raw <= (i < 4) ? 16'sd1000 : 16'sd0;
      cyc(4);
      chk("relay_flow", 32'(ev[i]), 32'(relay_on));
    end
  endtask : t_flow
  // Batch start, pause, resume, completion, restart refusal, resets
  task automatic t_batch();
    logic [31:0] d;
    int n, k;
    wr(FMR_OFF_TARGET, 32'h0000_0064, FMR_RESP_OKAY);
    wr(FMR_OFF_CTRL, 32'h0000_0042, FMR_RESP_OKAY);
    wr(FMR_OFF_PINCFG, 32'h0000_0004, FMR_RESP_OKAY);
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk("batch_on", 32'h1, 32'(relay_on));
    cyc(10);
    press(1'b1);
    d = batch_total;
    cyc(20);
    chk("pause_relay", 32'h0, 32'(relay_on));
    chk("pause_total", d, batch_total);
    press(1'b1);
    chk("resume", 32'h1, 32'(relay_on));
    n = 0;
    while (relay_on === 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200) tmo("batch_done_wait");
    rd(FMR_OFF_STATUS, FMR_RESP_OKAY, d);
    chk("done_state", 32'h3, 32'(d[2:1]));
    chk("predict", 32'h0000_005A, batch_total);
    press(1'b1);
    cyc(10);
    chk("done_refuse", 32'h0, 32'(relay_on));
    wr(FMR_OFF_PINCFG, 32'h0000_0005, FMR_RESP_OKAY);
    pin(0, 1'b1);
    chk("reset_total", 32'h0, batch_total);
    rd(FMR_OFF_STATUS, FMR_RESP_OKAY, d);
    chk("armed", 32'h0, 32'(d[2:1]));
    wr(FMR_OFF_PINCFG, 32'h0000_000C, FMR_RESP_OKAY);
    pin(0, 1'b0);
    cyc(20);
    wr(FMR_OFF_PINCFG, 32'h0000_0003, FMR_RESP_OKAY);
    pin(0, 1'b1);
    chk("meter_relay", 32'h0, 32'(relay_on));
    chk("meter_total", 32'h0, batch_total);
    rd(FMR_OFF_CTRL, FMR_RESP_OKAY, d);
    chk("meter_keeps", 32'h0000_0042, d);
    pin(0, 1'b0);
    rate <= -16'sd5;
    for (k = 0; k < 2; k++) begin
      wr(FMR_OFF_CTRL, k ? 32'h0000_0052 : 32'h0000_0042, FMR_RESP_OKAY);
      press(1'b1);
      cyc(20);
      press(1'b1);
      chk("reverse", k ? 32'h1 : 32'h0, k ? 32'(batch_total[31]) : batch_total);
      press(1'b0);
    end
  endtask : t_batch
  // Analog mode codes and linear scaling with clamps
  task automatic t_analog();
    int m;
    wr(FMR_OFF_ANALIM, 32'h0064_0000, FMR_RESP_OKAY);
    for (m = 0; m < 4; m++) begin
      wr(FMR_OFF_CTRL, 32'(m << 2), FMR_RESP_OKAY);
      flow_filt <= 16'sd200;
      cyc(4);
      chk("ana_mode", 32'(m), 32'(analog_mode));
      chk("ana_high", (m == 0) ? 32'h0 : 32'h0000_FFFF, 32'(analog_code));
    end
    flow_filt <= -16'sd10;
    cyc(4);
    chk("ana_low", 32'h0, 32'(analog_code));
    flow_filt <= 16'sd50;
    cyc(4);
    chk("ana_mid", 32'h1, 32'(analog_code >= 16'h7FFE && analog_code <= 16'h8000));
  endtask : t_analog
  // Instantaneous flow refresh
  task automatic t_status();
    logic [31:0] d;
    flow_raw <= 16'sd77;
    cyc(STAT + 4);
    chk("flow_status", 32'h4D, 32'(flow_status));
    flow_raw <= -16'sd3;
    cyc(STAT + 4);
    rd(FMR_OFF_FLOW, FMR_RESP_OKAY, d);
    chk("flow_reg", 32'hFFFF_FFFD, d);
  endtask : t_status
  // Main sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    sw_lvl = 2'b00;
    btn_l = 1'b0;
    btn_r = 1'b0;
    flow_filt = 16'sd0;
    flow_raw = 16'sd0;
    alarm_cond = 2'b00;
    rate = 16'sd10;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(2);
    t_regs();
    t_pins();
    t_alarm();
    t_flow();
    t_batch();
    t_analog();
    t_status();
    complete_run();
  end
endmodule : tb_fmr_ctrl
